// ---- logic/scs_regs.svh ----
// constants of the card supply sequencer: register map, fields, timing
// assumes a 40 MHz system clock on both ends
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH
// device supply control register and its fields
`define SCS_SUPPLY_CTRL_ADDR  5'h17
`define SCS_SUPPLY_CTRL_RESET 10'h000
`define SCS_SEL_BIT           0
`define SCS_REGEN_BIT         1
`define SCS_OK_BIT            2
`define SCS_SHIFT_BIT         3
// controller software registers
`define SCS_H_CTRL_ADDR       2'h0
`define SCS_H_STATUS_ADDR     2'h1
`define SCS_H_EVENT_ADDR      2'h2
`define SCS_H_MASK_ADDR       2'h3
`define SCS_H_CTRL_RESET      8'h00
`define SCS_H_MASK_RESET      3'h0
`define SCS_C_POWER_BIT       0
`define SCS_C_VOLT_BIT        1
`define SCS_C_SLEEP_BIT       2
`define SCS_C_CLKIDLE_BIT     3
`define SCS_C_RSTREL_BIT      4
`define SCS_E_READY_BIT       0
`define SCS_E_FAULT_BIT       1
`define SCS_E_OFF_BIT         2
// timing
`define SCS_CLK_MHZ           40
`define SCS_SETTLE_TIME_US    4000
`define SCS_SETTLE_CYC        (`SCS_SETTLE_TIME_US * `SCS_CLK_MHZ)
`define SCS_TIMEOUT_CYC       (2 * `SCS_SETTLE_CYC)
`define SCS_POLL_GAP_CYC      16
`define SCS_CARD_CLK_DIV      8
`endif

// ---- logic/scs_pkg.sv ----
// types shared by both ends of the card supply sequencer
// assumes scs_regs.svh supplies the numbers
package scs_pkg;
	typedef logic [9:0] scs_word_t;
	// controller sequence states, one-hot
	typedef enum logic [8:0] {
		SCS_IDLE  = 9'h001,
		SCS_SETUP = 9'h002,
		SCS_POLL  = 9'h004,
		SCS_RDREQ = 9'h008,
		SCS_CHECK = 9'h010,
		SCS_SHIFT = 9'h020,
		SCS_READY = 9'h040,
		SCS_OFF   = 9'h080,
		SCS_FAULT = 9'h100
	} scs_state_t;
endpackage

// ---- logic/scs_link_if.sv ----
// link between the supply device and its controlling baseband
// assumes both ends run on one sys_clk; data pin pulled up when released
`timescale 1ns/100ps
interface scs_link_if;
	logic [4:0] reg_addr;
	logic [9:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [9:0] reg_rdata;
	logic       host_card_clock_out;
	logic       host_card_reset_out;
	logic       host_card_power_ctrl;
	logic       host_data_o;
	logic       host_data_oe_n;
	logic       host_card_data_pin;
	logic       card_data_rx;
	// released pin rests high through the pull-up
	assign host_card_data_pin = host_data_oe_n | host_data_o;
	modport dev (
		input  reg_addr,
		input  reg_wdata,
		input  reg_wr,
		input  reg_rd,
		output reg_rdata,
		input  host_card_clock_out,
		input  host_card_reset_out,
		input  host_card_data_pin,
		output card_data_rx
	);
	modport host (
		output reg_addr,
		output reg_wdata,
		output reg_wr,
		output reg_rd,
		input  reg_rdata,
		output host_card_clock_out,
		output host_card_reset_out,
		output host_card_power_ctrl,
		output host_data_o,
		output host_data_oe_n,
		input  card_data_rx
	);
endinterface

// ---- logic/scs_supply_dev.sv ----
// device end: supply control register, regulator control, level shifters
// assumes the regulator good flag arrives asynchronously from analog
`timescale 1ns/100ps
`include "scs_regs.svh"
module scs_supply_dev
	import scs_pkg::*;
(
	input  wire logic   sys_clk,
	input  wire logic   rstn,
	scs_link_if.dev     link,
	input  wire logic   regulation_pin,
	output logic        card_voltage_select,
	output logic        card_regulator_enable,
	output logic        card_shifter_enable,
	output logic        card_clock_line,
	output logic        card_reset_line,
	output logic        card_data_o,
	output logic        card_data_oe_n,
	input  wire logic   card_data_i
);
	// ****************************************
	// register decode
	// ****************************************
	logic      sel_reg;
	logic      regen_reg;
	logic      shift_reg;
	logic      ok_meta_reg;
	logic      ok_sync_reg;
	logic      dat_meta_reg;
	logic      dat_sync_reg;
	scs_word_t rdata_reg;
	wire       hit = link.reg_addr == `SCS_SUPPLY_CTRL_ADDR;
	wire       ok  = ok_sync_reg & regen_reg; // no regulation without enable [RQ3]
	wire scs_word_t rd_word = {6'h00, shift_reg, ok, regen_reg, sel_reg};

	assign card_voltage_select   = sel_reg;   // one picks 2.9 V, zero 1.8 V [RQ1]
	assign card_regulator_enable = regen_reg; // [RQ2]
	assign card_shifter_enable   = shift_reg; // [RQ4]
	assign card_data_o           = 1'b0;      // open drain, only ever pulls low
	assign link.reg_rdata        = rdata_reg;

	// control bits; all clear at reset, regulator stays off [RQ5]
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			sel_reg   <= 1'b0;
			regen_reg <= 1'b0;
			shift_reg <= 1'b0;
		end
		else if (link.reg_wr && hit)
		begin
			sel_reg   <= link.reg_wdata[`SCS_SEL_BIT];   // [RQ1]
			regen_reg <= link.reg_wdata[`SCS_REGEN_BIT]; // [RQ2]
			shift_reg <= link.reg_wdata[`SCS_SHIFT_BIT]; // [RQ4]
		end
	end

	// read data one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			rdata_reg <= `SCS_SUPPLY_CTRL_RESET;
		else
			rdata_reg <= (link.reg_rd && hit) ? rd_word : 10'h000; // [RQ3]
	end

	// ****************************************
	// synchronisers
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			ok_meta_reg  <= 1'b0;
			ok_sync_reg  <= 1'b0;
			dat_meta_reg <= 1'b1;
			dat_sync_reg <= 1'b1;
		end
		else
		begin
			ok_meta_reg  <= regulation_pin;
			ok_sync_reg  <= ok_meta_reg;
			dat_meta_reg <= card_data_i;
			dat_sync_reg <= dat_meta_reg;
		end
	end

	// ****************************************
	// level shifters
	// ****************************************
	// shifters off: card lines low, data driven low so the rail can drain
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			card_clock_line   <= 1'b0;
			card_reset_line   <= 1'b0;
			card_data_oe_n    <= 1'b0;
			link.card_data_rx <= 1'b1;
		end
		else
		begin
			card_clock_line   <= shift_reg & link.host_card_clock_out;      // [RQ4]
			card_reset_line   <= shift_reg & link.host_card_reset_out;      // [RQ4]
			card_data_oe_n    <= shift_reg & link.host_card_data_pin;       // [RQ9]
			link.card_data_rx <= ~shift_reg | dat_sync_reg; // stays on in sleep [RQ10]
		end
	end
endmodule

// ---- logic/scs_host_ctrl.sv ----
// baseband end: sequences card supply bring-up, sleep and shutdown
// assumes software on a plain strobe port and the device on scs_link_if
//
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
`include "scs_regs.svh"
// What this block and scs_supply_dev do
// (RQ1) voltage bit: one 2.9 V, zero 1.8 V
// (RQ2) regulator enable bit, read-write, resets zero
// (RQ3) read-only flag shows regulator in regulation
// (RQ4) shifter enable bit gates clock, reset, data
// (RQ5) regulator stays off after power-up
// (RQ6) host writes voltage and enable, then polls
// (RQ7) shifters enabled only after regulation flag set
// (RQ8) allow about 4 ms regulator settling
// (RQ9) shifters off drive card data low
// (RQ10) sleep keeps regulator and shifters enabled
// (RQ11) sleep holds card reset high
// (RQ12) sleep freezes card clock at chosen level
// (RQ13) sleep releases data pin to input
// (RQ14) sleep drives power control high
// (RQ15) no regulation within timeout reports supply fault
module scs_host_ctrl
	import scs_pkg::*;
#(
	parameter int TIMEOUT_CYC  = `SCS_TIMEOUT_CYC,
	parameter int POLL_GAP_CYC = `SCS_POLL_GAP_CYC,
	parameter int CLK_DIV      = `SCS_CARD_CLK_DIV
)
(
	input  wire logic   sys_clk,
	input  wire logic   rstn,
	input  wire logic   [1:0] sw_addr,
	input  wire logic   [7:0] sw_wdata,
	input  wire logic   sw_wr,
	input  wire logic   sw_rd,
	output logic        [8:0] sw_rdata,
	output logic        irq,
	input  wire logic   tx_low,
	output logic        rx_data,
	scs_link_if.host    link
);
	// ****************************************
	// software registers
	// ****************************************
	logic [7:0]  ctrl_reg;
	logic [2:0]  event_reg;
	logic [2:0]  event_next;
	logic [2:0]  mask_reg;
	logic [8:0]  rdata_reg;
	scs_state_t  st_reg;
	scs_state_t  st_next;
	logic [31:0] tmo_cnt_reg;
	logic [7:0]  gap_cnt_reg;
	logic [7:0]  div_cnt_reg;
	logic        clk_reg;
	logic        rst_reg;
	logic        drive_reg;
	logic        pwr_reg;
	logic [9:0]  wdata_reg;
	wire power_on = ctrl_reg[`SCS_C_POWER_BIT];
	wire volt_hi  = ctrl_reg[`SCS_C_VOLT_BIT];
	wire sleep    = ctrl_reg[`SCS_C_SLEEP_BIT] && st_reg == SCS_READY;
	wire clk_idle = ctrl_reg[`SCS_C_CLKIDLE_BIT];
	wire rst_rel  = ctrl_reg[`SCS_C_RSTREL_BIT];
	wire wr_ctrl  = sw_wr && sw_addr == `SCS_H_CTRL_ADDR;
	wire wr_mask  = sw_wr && sw_addr == `SCS_H_MASK_ADDR;
	wire rd_event = sw_rd && sw_addr == `SCS_H_EVENT_ADDR;
	wire ok_seen  = link.reg_rdata[`SCS_OK_BIT];
	wire timed_out = tmo_cnt_reg >= 32'(TIMEOUT_CYC);
	wire gap_done  = gap_cnt_reg >= 8'(POLL_GAP_CYC - 1);
	wire div_tick  = div_cnt_reg >= 8'(CLK_DIV / 2 - 1);

	// register read selection
	wire [8:0] rd_sel =
		(sw_addr == `SCS_H_CTRL_ADDR)   ? {1'b0, ctrl_reg} :
		(sw_addr == `SCS_H_STATUS_ADDR) ? st_reg :
		(sw_addr == `SCS_H_EVENT_ADDR)  ? {6'h00, event_reg} :
		                                  {6'h00, mask_reg};

	// events raised on entry to ready and fault, and on shutdown through off
	wire [2:0] ev_set = {
		st_reg == SCS_OFF,
		st_reg != SCS_FAULT && st_next == SCS_FAULT,
		st_reg != SCS_READY && st_next == SCS_READY};

	// a set in the clearing read wins so no event is lost
	assign event_next = (rd_event ? 3'h0 : event_reg) | ev_set;
	assign irq        = |(event_reg & mask_reg);
	assign sw_rdata   = rdata_reg;

	// software register writes and reads
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			ctrl_reg  <= `SCS_H_CTRL_RESET;
			mask_reg  <= `SCS_H_MASK_RESET;
			event_reg <= 3'h0;
			rdata_reg <= 9'h000;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_reg <= sw_wdata;
			if (wr_mask)
				mask_reg <= sw_wdata[2:0];
			event_reg <= event_next;
			rdata_reg <= sw_rd ? rd_sel : 9'h000;
		end
	end

	// ****************************************
	// supply sequence
	// ****************************************
	// device bus: strobes decoded from state, data from flops
	assign link.reg_addr  = `SCS_SUPPLY_CTRL_ADDR;
	assign link.reg_wr    = st_reg == SCS_SETUP || st_reg == SCS_SHIFT
		|| st_reg == SCS_OFF;
	assign link.reg_rd    = st_reg == SCS_RDREQ;
	assign link.reg_wdata = wdata_reg;

	// next state
	always_comb
	begin
		st_next = st_reg;
		case (st_reg)
			SCS_IDLE:
				if (power_on)
					st_next = SCS_SETUP;
			SCS_SETUP:
				st_next = SCS_POLL;                 // voltage and enable written [RQ6]
			SCS_POLL:
				if (timed_out)
					st_next = SCS_FAULT;            // [RQ15]
				else if (gap_done)
					st_next = SCS_RDREQ;
			SCS_RDREQ:
				st_next = SCS_CHECK;
			SCS_CHECK:
				if (ok_seen)
					st_next = SCS_SHIFT;            // shifters only after regulation [RQ7]
				else
					st_next = SCS_POLL;             // keep polling through settling [RQ8]
			SCS_SHIFT:
				st_next = SCS_READY;
			SCS_READY:
				if (!power_on && !sleep)
					st_next = SCS_OFF;              // supply never dropped in sleep [RQ10]
			SCS_OFF:
				st_next = SCS_IDLE;
			SCS_FAULT:
				if (!power_on)
					st_next = SCS_IDLE;
			default:
				st_next = SCS_IDLE;
		endcase
	end

	// state, settle timeout and poll spacing
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			st_reg      <= SCS_IDLE;
			tmo_cnt_reg <= 32'h0000_0000;
			gap_cnt_reg <= 8'h00;
		end
		else
		begin
			st_reg      <= st_next;
			tmo_cnt_reg <= (st_reg == SCS_IDLE) ? 32'h0000_0000 : tmo_cnt_reg + 32'h0000_0001;
			gap_cnt_reg <= (st_reg == SCS_POLL) ? gap_cnt_reg + 8'h01 : 8'h00;
		end
	end

	// write data set up as each write state is entered
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			wdata_reg <= 10'h000;
		else if (st_next == SCS_SETUP)
			wdata_reg <= 10'((volt_hi << `SCS_SEL_BIT) | (1 << `SCS_REGEN_BIT)); // [RQ6]
		else if (st_next == SCS_SHIFT)
			wdata_reg <= wdata_reg | 10'(1 << `SCS_SHIFT_BIT);                   // [RQ7]
		else if (st_next == SCS_OFF)
			wdata_reg <= 10'h000;
	end

	// a fault leaves the regulator on; software clears power_on to reset
	// the sequence and a later bring-up rewrites the device anyway

	// ****************************************
	// card pins
	// ****************************************
	// card clock divider; slower rate is an enable pulse only
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			div_cnt_reg <= 8'h00;
		else
			div_cnt_reg <= div_tick ? 8'h00 : div_cnt_reg + 8'h01;
	end

	// pin levels; sleep overrides everything the card sees
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			clk_reg   <= 1'b0;
			rst_reg   <= 1'b0;
			drive_reg <= 1'b0;
			pwr_reg   <= 1'b0;
			rx_data   <= 1'b1;
		end
		else
		begin
			if (sleep)
				clk_reg <= clk_idle;                // frozen at card's level [RQ12]
			else if (st_reg != SCS_READY)
				clk_reg <= 1'b0;
			else if (div_tick)
				clk_reg <= ~clk_reg;
			rst_reg   <= sleep | (st_reg == SCS_READY && rst_rel); // inactive high [RQ11]
			drive_reg <= !sleep && st_reg == SCS_READY && tx_low;  // input in sleep [RQ13]
			pwr_reg   <= sleep | (st_reg != SCS_IDLE && st_reg != SCS_FAULT); // [RQ14]
			rx_data   <= link.card_data_rx;
		end
	end

	assign link.host_card_clock_out  = clk_reg;
	assign link.host_card_reset_out  = rst_reg;
	assign link.host_card_power_ctrl = pwr_reg;
	assign link.host_data_o          = 1'b0;
	assign link.host_data_oe_n       = ~drive_reg;
endmodule

// ---- verification/scs_link_monitor.sv ----
// checks on the link between supply device and baseband
// assumes one sys_clk and a synchronous active-low rstn
`timescale 1ns/100ps
`include "scs_regs.svh"
module scs_link_monitor
(
	input logic       sys_clk,
	input logic       rstn,
	input logic [4:0] reg_addr,
	input logic [9:0] reg_wdata,
	input logic       reg_wr,
	input logic       reg_rd,
	input logic [9:0] reg_rdata,
	input logic       host_card_power_ctrl,
	input logic       card_data_rx
);
	logic shift_on_reg;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	// last written shifter bit, mirrors the device field
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			shift_on_reg <= 1'b0;
		else if (reg_wr)
			shift_on_reg <= reg_wdata[3];
	end
	// ************
	// link checks
	// ************
	sequence s_ok_read;
		reg_rd ##1 reg_rdata[2];
	endsequence
	sequence s_bad_read;
		reg_rd ##1 !reg_rdata[2];
	endsequence
	sequence s_setup_wr;
		reg_wr && reg_wdata[1] && !reg_wdata[3];
	endsequence
	a_addr_fixed: assert property ((reg_wr || reg_rd) |->
		reg_addr == `SCS_SUPPLY_CTRL_ADDR) else $error("access off control address");
	a_setup_poll: assert property (s_setup_wr |-> ##[1:24] reg_rd)
		else $error("no poll after regulator enable");
	a_read_fields: assert property (reg_rd |=>
		reg_rdata[9:4] == 6'h00 && (!reg_rdata[2] || reg_rdata[1]))
		else $error("bad control read value");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 10'h000)
		else $error("read data outside answer cycle");
	a_ok_shift: assert property (s_ok_read |=> reg_wr && reg_wdata[3])
		else $error("shifters not enabled after ok");
	a_shift_after_ok: assert property (reg_wr && reg_wdata[3] |->
		$past(reg_rdata[2])) else $error("shifters enabled without ok");
	a_retry_poll: assert property (s_bad_read |->
		##[1:24] (reg_rd || !host_card_power_ctrl)) else $error("poll stalled");
	a_shift_with_reg: assert property (reg_wr && reg_wdata[3] |-> reg_wdata[1])
		else $error("shifters on without regulator");
	a_rx_idle_high: assert property (!$past(shift_on_reg) |-> card_data_rx)
		else $error("card data seen with shifters off");
endmodule

// ---- verification/test_sim_card_supply_enable_sequencer.sv ----
// bench: both ends joined by the link, software port driven by tasks
// assumes design files under logic/ and a 40 MHz sys_clk
`timescale 1ns/100ps
`include "scs_regs.svh"
module test_sim_card_supply_enable_sequencer;
	logic       sys_clk = 1'b0;
	logic       rstn = 1'b0;
	logic [1:0] sw_addr = 2'h0;
	logic [7:0] sw_wdata = 8'h00;
	logic       sw_wr = 1'b0;
	logic       sw_rd = 1'b0;
	logic       tx_low = 1'b0;
	logic       regulation_pin = 1'b0;
	logic       card_data_i = 1'b1;
	logic [8:0] sw_rdata;
	logic       irq;
	logic       rx_data;
	logic       card_voltage_select;
	logic       card_regulator_enable;
	logic       card_shifter_enable;
	logic       card_clock_line;
	logic       card_reset_line;
	logic       card_data_oe_n;
	int         n_fail = 0;
	int         check_count = 0;
	always #12.5 sys_clk = ~sys_clk;
	scs_link_if link_bus ();
	scs_supply_dev u_scs_supply_dev (.sys_clk(sys_clk), .rstn(rstn), .link(link_bus.dev),
		.regulation_pin(regulation_pin), .card_voltage_select(card_voltage_select),
		.card_regulator_enable(card_regulator_enable), .card_shifter_enable(card_shifter_enable),
		.card_clock_line(card_clock_line), .card_reset_line(card_reset_line),
		.card_data_o(), .card_data_oe_n(card_data_oe_n), .card_data_i(card_data_i));
	// short timeout keeps the fault case brief
	scs_host_ctrl #(.TIMEOUT_CYC(200)) u_scs_host_ctrl (.sys_clk(sys_clk), .rstn(rstn),
		.sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
		.sw_rdata(sw_rdata), .irq(irq), .tx_low(tx_low), .rx_data(rx_data),
		.link(link_bus.host));
	scs_link_monitor u_scs_link_monitor (.sys_clk(sys_clk), .rstn(rstn),
		.reg_addr(link_bus.reg_addr), .reg_wdata(link_bus.reg_wdata),
		.reg_wr(link_bus.reg_wr), .reg_rd(link_bus.reg_rd), .reg_rdata(link_bus.reg_rdata),
		.host_card_power_ctrl(link_bus.host_card_power_ctrl),
		.card_data_rx(link_bus.card_data_rx));
	// ************
	// tasks
	// ************
	task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic sw_write(input logic [1:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge sys_clk);
		sw_wr <= 1'b0;
	endtask
	// data stand only in the cycle after the strobe
	task automatic sw_read(input logic [1:0] a, output logic [8:0] d);
		@(posedge sys_clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge sys_clk);
		sw_rd <= 1'b0;
		#1;
		d = sw_rdata;
	endtask
	task automatic rd_check(input logic [1:0] a, input logic [8:0] exp, input string what);
		logic [8:0] d;
		sw_read(a, d);
		check(what, exp, d);
	endtask
	task automatic pins(input logic rp, input logic tl, input logic cd, input int n);
		@(posedge sys_clk);
		regulation_pin <= rp;
		tx_low <= tl;
		card_data_i <= cd;
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wait_irq();
		for (int i = 0; i < 400 && irq !== 1'b1; i++)
		begin
			@(posedge sys_clk);
			#1;
		end
		check("irq", 1'b1, irq);
	endtask
	// ************
	// scenarios
	// ************
	task automatic t_reset();
		rd_check(2'h0, 9'h000, "ctrl");
		rd_check(2'h1, 9'h001, "status");
		rd_check(2'h2, 9'h000, "event");
		rd_check(2'h3, 9'h000, "mask");
		check("regulator", 1'b0, card_regulator_enable);
		check("shifter", 1'b0, card_shifter_enable);
		check("drive_n", 1'b0, card_data_oe_n);
	endtask
	// regulator never settles, so the host has to give up
	task automatic t_fault();
		pins(1'b0, 1'b0, 1'b1, 1);
		sw_write(2'h0, 8'h01);
		wait_irq();
		rd_check(2'h2, 9'h002, "fault event");
		rd_check(2'h1, 9'h100, "fault state");
		check("irq clear", 1'b0, irq);
		check("regulator", 1'b1, card_regulator_enable);
		check("shifter", 1'b0, card_shifter_enable);
		sw_write(2'h0, 8'h00);
		pins(1'b0, 1'b0, 1'b1, 2);
		rd_check(2'h1, 9'h001, "idle");
	endtask
	task automatic t_bringup(input logic v);
		logic c;
		pins(1'b1, 1'b0, 1'b1, 1);
		sw_write(2'h0, {3'h0, 1'b1, 2'h0, v, 1'b1});
		wait_irq();
		rd_check(2'h2, 9'h001, "ready event");
		rd_check(2'h1, 9'h040, "ready state");
		check("volt", v, card_voltage_select);
		check("regulator", 1'b1, card_regulator_enable);
		check("shifter", 1'b1, card_shifter_enable);
		// card clock must run once shifters pass it: one toggle per half period
		c = card_clock_line;
		repeat (`SCS_CARD_CLK_DIV / 2) @(posedge sys_clk);
		#1;
		check("clock run", {9'h000, !c}, {9'h000, card_clock_line});
		check("card reset", 1'b1, card_reset_line);
		pins(1'b1, 1'b1, 1'b0, 6);
		check("drive_n", 1'b0, card_data_oe_n);
		check("rx_data", 1'b0, rx_data);
		pins(1'b1, 1'b0, 1'b1, 6);
		check("release", 1'b1, card_data_oe_n);
		check("rx_data", 1'b1, rx_data);
	endtask
	// sleep must keep the supply up and the clock still
	task automatic t_sleep(input logic lvl);
		logic c;
		sw_write(2'h0, {3'h0, 1'b1, lvl, 3'h7});
		// host asks to drive data low; sleep has to release the pin anyway
		pins(1'b1, 1'b1, 1'b1, 4);
		c = card_clock_line;
		pins(1'b1, 1'b1, 1'b1, 20);
		check("clock still", c, card_clock_line);
		check("clock level", lvl, card_clock_line);
		check("card reset", 1'b1, card_reset_line);
		check("data pin", 1'b1, link_bus.host_card_data_pin);
		check("power ctrl", 1'b1, link_bus.host_card_power_ctrl);
		check("regulator", 1'b1, card_regulator_enable);
		check("shifter", 1'b1, card_shifter_enable);
		sw_write(2'h0, 8'h13);
	endtask
	// shutdown with the interrupt masked off
	task automatic t_shutdown();
		logic [8:0] d;
		sw_write(2'h3, 8'h00);
		sw_write(2'h0, 8'h00);
		d = 9'h000;
		for (int i = 0; i < 20 && d !== 9'h001; i++)
			sw_read(2'h1, d);
		check("idle", 9'h001, d);
		check("irq masked", 1'b0, irq);
		rd_check(2'h2, 9'h004, "off event");
		check("regulator", 1'b0, card_regulator_enable);
		check("shifter", 1'b0, card_shifter_enable);
		check("drive_n", 1'b0, card_data_oe_n);
		check("rx_data", 1'b1, rx_data);
		sw_write(2'h3, 8'h07);
	endtask
	// reset while powered: everything must fall back to off
	task automatic t_mid_reset();
		@(posedge sys_clk);
		rstn <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		t_reset();
	endtask
	// watchdog: the whole sequence needs a few hundred cycles
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		results();
	end
	initial
	begin
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		t_reset();
		sw_write(2'h3, 8'h07);
		t_fault();
		t_bringup(1'b1);
		t_sleep(1'b1);
		t_sleep(1'b0);
		t_shutdown();
		t_bringup(1'b0);
		t_shutdown();
		t_bringup(1'b1);
		t_mid_reset();
		results();
	end
endmodule
